// File: rtl/wss_sequencer.sv
// Waveform step sequencer: AHB-Lite register slave, step table and playout control.
// Assumes triggers, pattern requests and play_done are one-cycle pulses on clk_sys.
//
// Functional notes
// (R01) Default steps play once each, in ascending order, with no trigger.
// (R02) Event branch beats the after-step target at the same step.
// (R03) Wait source off: the step's waveform starts at once.
// (R04) Wait source set: step idles until that trigger arrives.
// (R05) Steps inside a subsequence never wait.
// (R06) After-step next goes to following step; last wraps to first.
// (R07) Next on a subsequence's last step returns to the parent.
// (R08) After-step first or last jumps to the sequence's first or last step.
// (R09) After-step end stops; inside a subsequence the parent continues.
// (R10) An explicit index as after-step target is jumped to directly.
// (R11) A step replays its waveform or subsequence the programmed count.
// (R12) Repeat count zero repeats until some branch occurs.
// (R13) Event source off: no trigger branching for that step.
// (R14) A matching trigger during the step branches to the event target.
// (R15) Immediate mode branches at once and aborts the playing waveform.
// (R16) Deferred mode keeps the trigger and branches when the waveform ends.
// (R17) One timing mode serves both event and pattern branches.
// (R18) Event target may be next, first, last or an index.
// (R19) Event settings of subsequence steps are ignored.
// (R20) Override branches to first, last, current, end or an index.
// (R21) The current step index is readable at any time.
// (R22) Priority: override, then pattern, then event, then after-step.
// (R23) Host never nests a subsequence inside a subsequence.
// (R24) Triggers arrive as single-cycle pulses on the sequencer clock.
module wss_sequencer
	import wss_pkg::*;
#(
	parameter int STEP_W = 8
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire logic          trigger_input_a,
	input  wire logic          trigger_input_b,
	input  wire logic          trigger_internal,
	input  wire logic          pattern_branch_req,
	input  wire logic [7:0]    pattern_branch_step,
	input  wire logic          play_done,
	output wss_play_cmd_t      play_cmd
);
	generate
		if (STEP_W < 1 || STEP_W > STEP_IDX_MAX_W) begin : g_bad_width
			$error("STEP_W must lie between 1 and 8");
		end
	endgenerate
	localparam int DEPTH = 1 << STEP_W;
	typedef logic [STEP_W-1:0] idx_t;

	////////////////////////////////////////////////////////////////////////
	// Register bus
	logic       dp_wr;
	logic [7:0] dp_addr;
	logic       defer_mode;
	logic [31:0] seq_range;
	idx_t        step_sel;
	wss_step_cfg_t cfg_mem [DEPTH];
	logic [31:0]   tgt_mem [DEPTH];
	logic [31:0]   loop_mem [DEPTH];
	wire addr_ph   = hsel & htrans[1] & hready;
	wire wr_ctrl   = dp_wr && dp_addr == OFF_CTRL;
	wire wr_range  = dp_wr && dp_addr == OFF_SEQ_RANGE;
	wire wr_ovr    = dp_wr && dp_addr == OFF_OVERRIDE;
	wire wr_sel    = dp_wr && dp_addr == OFF_STEP_SEL;
	wire wr_cfg    = dp_wr && dp_addr == OFF_STEP_CFG;
	wire wr_tgt    = dp_wr && dp_addr == OFF_STEP_TGT;
	wire wr_loop   = dp_wr && dp_addr == OFF_STEP_LOOP;
	wire cmd_start = wr_ctrl & hwdata[CTRL_START_BIT];
	wire cmd_stop  = wr_ctrl & hwdata[CTRL_STOP_BIT];
	wss_state_t st;
	idx_t       top_step;
	idx_t       sub_step;
	logic       in_sub;
	logic [31:0] top_cnt;
	logic [31:0] sub_cnt;
	logic        pend_v;
	logic        pend_pat;
	logic        pend_stop;
	idx_t        pend_idx;
	wire [31:0] status_word = {12'h000, pend_v, st == ST_WAIT, st != ST_IDLE, in_sub,
		8'(sub_step), 8'(top_step)};
	logic [31:0] rd_mux;
	always_comb begin
		unique case (haddr[7:0])
			OFF_CTRL:      rd_mux = {30'h0000_0000, defer_mode, 1'b0};
			OFF_STATUS:    rd_mux = status_word; // R21
			OFF_SEQ_RANGE: rd_mux = seq_range;
			OFF_STEP_SEL:  rd_mux = 32'(step_sel);
			OFF_STEP_CFG:  rd_mux = 32'(cfg_mem[step_sel]);
			OFF_STEP_TGT:  rd_mux = tgt_mem[step_sel];
			OFF_STEP_LOOP: rd_mux = loop_mem[step_sel];
			default:       rd_mux = 32'h0000_0000;
		endcase
	end
	// Read data is fetched in the address phase, so every access ends with zero wait states
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr     <= 1'b0;
			dp_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_wr     <= addr_ph & hwrite;
			dp_addr   <= haddr[7:0];
			hrdata    <= (addr_ph & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			defer_mode <= 1'b0;
			seq_range  <= RST_SEQ_RANGE;
			step_sel   <= '0;
		end else begin
			if (wr_ctrl)
				defer_mode <= hwdata[CTRL_DEFER_BIT]; // R17
			if (wr_range)
				seq_range <= hwdata;
			if (wr_sel)
				step_sel <= hwdata[STEP_W-1:0];
		end
	end
	// Table resets to all-default steps: no wait, no event, next, one play
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				cfg_mem[i]  <= '0; // R01
				tgt_mem[i]  <= 32'h0000_0000;
				loop_mem[i] <= RST_LOOP;
			end
		end else begin
			if (wr_cfg)
				cfg_mem[step_sel] <= wss_step_cfg_t'(hwdata[10:0]);
			if (wr_tgt)
				tgt_mem[step_sel] <= hwdata;
			if (wr_loop)
				loop_mem[step_sel] <= hwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Step decode
	function automatic logic trig_hit(input logic [1:0] src, input logic a, input logic b, input logic t);
		trig_hit = (src == SRC_A && a) || (src == SRC_B && b) || (src == SRC_INT && t);
	endfunction
	// Returns {stop, index}; next wraps from last to first
	function automatic logic [STEP_W:0] resolve(input logic [2:0] kind, input idx_t ix, input idx_t cur,
		input idx_t first, input idx_t last);
		unique case (kind)
			TK_NEXT:    resolve = {1'b0, (cur == last) ? first : idx_t'(cur + 1'b1)}; // R06
			TK_FIRST:   resolve = {1'b0, first}; // R08
			TK_LAST:    resolve = {1'b0, last}; // R08
			TK_END:     resolve = {1'b1, cur}; // R09
			TK_INDEX:   resolve = {1'b0, ix}; // R10
			TK_CURRENT: resolve = {1'b0, cur};
			default:    resolve = {1'b0, cur};
		endcase
	endfunction
	wire idx_t seq_first = seq_range[RANGE_FIRST_LSB +: STEP_W];
	wire idx_t seq_last  = seq_range[RANGE_LAST_LSB +: STEP_W];
	wire idx_t act_idx   = in_sub ? sub_step : top_step;
	wire wss_step_cfg_t t_cfg = cfg_mem[top_step];
	wire wss_step_cfg_t a_cfg = cfg_mem[act_idx];
	wire [31:0] t_tgt    = tgt_mem[top_step];
	wire [31:0] a_tgt    = tgt_mem[act_idx];
	wire [31:0] t_loop   = loop_mem[top_step];
	wire [31:0] a_loop   = loop_mem[act_idx];
	wire idx_t sub_first = t_tgt[TGT_WAVE_LSB +: STEP_W];
	wire idx_t sub_last  = t_tgt[TGT_SUB_LAST_LSB +: STEP_W];
	wire wait_hit = trig_hit(t_cfg.wait_src, trigger_input_a, trigger_input_b, trigger_internal);
	// Only the top-level step's event source counts; subsequence steps have none
	wire ev_hit = st == ST_PLAY && t_cfg.event_src != SRC_OFF // R13 R19
		&& trig_hit(t_cfg.event_src, trigger_input_a, trigger_input_b, trigger_internal); // R14
	wire pat_hit = pattern_branch_req && (st == ST_PLAY || st == ST_WAIT);
	wire [STEP_W:0] ev_res  = resolve(t_cfg.event_kind, t_tgt[TGT_EVENT_IDX_LSB +: STEP_W], top_step,
		seq_first, seq_last); // R18
	wire [STEP_W:0] ovr_res = resolve(hwdata[OVR_KIND_LSB +: 3], hwdata[OVR_IDX_LSB +: STEP_W], top_step,
		seq_first, seq_last); // R20
	wire [STEP_W:0] pat_res = {1'b0, pattern_branch_step[STEP_W-1:0]};
	// Override is never deferred; the timing mode governs pattern and event branches alike
	wire imm_any = wr_ovr || (!defer_mode && (pat_hit || ev_hit)); // R15 R17
	wire [STEP_W:0] imm_res = wr_ovr ? ovr_res : (pat_hit ? pat_res : ev_res); // R22
	// Completion arithmetic for the step that just finished one play
	wire [31:0] a_cnt_nx  = (in_sub ? sub_cnt : top_cnt) + 32'h0000_0001;
	wire        a_fin     = a_loop != 32'h0000_0000 && a_cnt_nx == a_loop; // R11 R12
	wire [31:0] t_cnt_nx  = top_cnt + 32'h0000_0001;
	wire        t_fin     = t_loop != 32'h0000_0000 && t_cnt_nx == t_loop;
	wire        pass_done = a_cfg.after_kind == TK_END
		|| (a_cfg.after_kind == TK_NEXT && sub_step == sub_last); // R07 R09
	wire [STEP_W:0] t_after = resolve(t_cfg.after_kind, t_tgt[TGT_AFTER_IDX_LSB +: STEP_W], top_step,
		seq_first, seq_last);
	wire [STEP_W:0] s_after = resolve(a_cfg.after_kind, a_tgt[TGT_AFTER_IDX_LSB +: STEP_W], sub_step,
		sub_first, sub_last);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	wss_state_t next_st;
	idx_t       next_top;
	idx_t       next_sub;
	logic       next_in_sub;
	logic [31:0] next_tcnt;
	logic [31:0] next_scnt;
	logic        next_start;
	logic        next_abort;
	logic        next_pend_v;
	logic        next_pend_pat;
	logic [STEP_W:0] jump;
	logic        do_jump;
	always_comb begin
		next_st       = st;
		next_top      = top_step;
		next_sub      = sub_step;
		next_in_sub   = in_sub;
		next_tcnt     = top_cnt;
		next_scnt     = sub_cnt;
		next_start    = 1'b0;
		next_abort    = 1'b0;
		next_pend_v   = pend_v;
		next_pend_pat = pend_pat;
		jump          = {1'b0, top_step};
		do_jump       = 1'b0;
		if (imm_any) begin
			do_jump    = 1'b1; // R15 R22
			jump       = imm_res;
			next_abort = st == ST_PLAY;
			next_pend_v = 1'b0;
		end else if (cmd_stop) begin
			next_st    = ST_IDLE;
			next_abort = st == ST_PLAY;
		end else begin
			if (defer_mode && (pat_hit || ev_hit) && (!pend_v || (pat_hit && !pend_pat))) begin
				next_pend_v   = 1'b1; // R16
				next_pend_pat = pat_hit;
			end
			unique case (st)
				ST_IDLE:
					if (cmd_start) begin
						do_jump = 1'b1;
						jump    = {1'b0, seq_first}; // R01
					end
				ST_FETCH:
					if (t_cfg.wait_src != SRC_OFF)
						next_st = ST_WAIT; // R04
					else
						next_st = ST_START; // R03
				ST_WAIT:
					if (wait_hit)
						next_st = ST_START; // R04
				ST_START: begin
					if (t_cfg.is_sub && !in_sub) begin
						next_in_sub = 1'b1; // R05
						next_sub    = sub_first;
						next_scnt   = 32'h0000_0000;
					end else begin
						next_start = 1'b1;
						next_st    = ST_PLAY;
					end
				end
				ST_PLAY:
					if (play_done) begin
						if (pend_v) begin
							do_jump     = 1'b1; // R16 R02
							jump        = {pend_stop, pend_idx};
							next_pend_v = 1'b0;
						end else if (!a_fin) begin
							next_st = ST_START; // R12
							if (in_sub)
								next_scnt = a_cnt_nx;
							else
								next_tcnt = a_cnt_nx;
						end else if (!in_sub) begin
							do_jump = 1'b1; // R06 R08 R09 R10
							jump    = t_after;
						end else if (!pass_done) begin
							next_st   = ST_START; // R07
							next_sub  = s_after[STEP_W-1:0];
							next_scnt = 32'h0000_0000;
						end else if (!t_fin) begin
							next_st   = ST_START; // R11
							next_tcnt = t_cnt_nx;
							next_sub  = sub_first;
							next_scnt = 32'h0000_0000;
						end else begin
							do_jump = 1'b1; // R07 R09
							jump    = t_after;
						end
					end
				default:
					next_st = ST_IDLE;
			endcase
		end
		if (do_jump) begin
			next_st     = jump[STEP_W] ? ST_IDLE : ST_FETCH;
			next_top    = jump[STEP_W-1:0];
			next_in_sub = 1'b0;
			next_tcnt   = 32'h0000_0000;
			next_scnt   = 32'h0000_0000;
			next_pend_v = 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st       <= ST_IDLE;
			top_step <= '0;
			sub_step <= '0;
			in_sub   <= 1'b0;
			top_cnt  <= 32'h0000_0000;
			sub_cnt  <= 32'h0000_0000;
			pend_v   <= 1'b0;
			pend_pat <= 1'b0;
		end else begin
			st       <= next_st;
			top_step <= next_top;
			sub_step <= next_sub;
			in_sub   <= next_in_sub;
			top_cnt  <= next_tcnt;
			sub_cnt  <= next_scnt;
			pend_v   <= next_pend_v;
			pend_pat <= next_pend_pat;
		end
	end
	// Deferred target is resolved when the trigger lands, so a later step change cannot skew it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_stop <= 1'b0;
			pend_idx  <= '0;
		end else if (next_pend_v && !pend_v || (pat_hit && defer_mode && !pend_pat && next_pend_pat)) begin
			{pend_stop, pend_idx} <= pat_hit ? pat_res : ev_res; // R22
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			play_cmd <= '0;
		else begin
			play_cmd.start <= next_start;
			play_cmd.abort <= next_abort; // R15
			if (next_start)
				play_cmd.wave <= a_tgt[TGT_WAVE_LSB +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_top_done;
		st == ST_PLAY && play_done && !in_sub && !pend_v && !imm_any && !cmd_stop;
	endsequence
	sequence s_quiet;
		!imm_any && !cmd_stop;
	endsequence
	nowait_start_a: assert property ((st == ST_FETCH && t_cfg.wait_src == SRC_OFF && !t_cfg.is_sub && !imm_any
		&& !cmd_stop) ##1 s_quiet |=> play_cmd.start) // R03
		else $error("step without wait did not start");
	wait_hold_a: assert property (st == ST_WAIT && !wait_hit && !imm_any && !cmd_stop |=> st == ST_WAIT
		&& !play_cmd.start) // R04
		else $error("waiting step left wait without trigger");
	sub_nowait_a: assert property (st == ST_START && t_cfg.is_sub && !in_sub ##0 s_quiet |=> in_sub
		##1 (play_cmd.start || imm_any || cmd_stop || $past(imm_any) || $past(cmd_stop))) // R05
		else $error("subsequence step did not start at once");
	wrap_first_a: assert property (s_top_done ##0 (a_fin && t_cfg.after_kind == TK_NEXT
		&& top_step == seq_last) |=> top_step == seq_first && st == ST_FETCH) // R06
		else $error("next on last step did not wrap");
	end_stop_a: assert property (s_top_done ##0 (a_fin && t_cfg.after_kind == TK_END) |=> st == ST_IDLE) // R09
		else $error("end target did not stop");
	inf_loop_a: assert property (s_top_done ##0 (a_loop == 32'h0000_0000) |=> st == ST_START
		&& top_step == $past(top_step)) // R12
		else $error("infinite step did not replay");
	imm_abort_a: assert property (ev_hit && !defer_mode && !wr_ovr && !pat_hit |=> play_cmd.abort
		&& top_step == $past(ev_res[STEP_W-1:0]) && st != ST_PLAY) // R15
		else $error("immediate event branch missed");
	defer_keep_a: assert property (ev_hit && defer_mode && !wr_ovr && !cmd_stop && !play_done |=> pend_v
		&& !play_cmd.abort && top_step == $past(top_step)) // R16
		else $error("deferred event branch not held");
	ovr_first_a: assert property (wr_ovr && !ovr_res[STEP_W] |=> top_step == $past(ovr_res[STEP_W-1:0])
		&& st == ST_FETCH) // R20
		else $error("override branch missed");
	bus_ready_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or errored");
endmodule

// File: rtl/wss_pkg.sv
// Constants and types shared by the waveform step sequencer.
// Assumes a 32-bit AHB-Lite register bus and a step table of at most 256 entries.
package wss_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_SEQ_RANGE = 8'h08;
	localparam logic [7:0] OFF_OVERRIDE  = 8'h0C;
	localparam logic [7:0] OFF_STEP_SEL  = 8'h10;
	localparam logic [7:0] OFF_STEP_CFG  = 8'h14;
	localparam logic [7:0] OFF_STEP_TGT  = 8'h18;
	localparam logic [7:0] OFF_STEP_LOOP = 8'h1C;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_START_BIT    = 0;
	localparam int CTRL_DEFER_BIT    = 1;
	localparam int CTRL_STOP_BIT     = 2;
	localparam int RANGE_FIRST_LSB   = 0;
	localparam int RANGE_LAST_LSB    = 8;
	localparam int OVR_IDX_LSB       = 0;
	localparam int OVR_KIND_LSB      = 8;
	localparam int TGT_AFTER_IDX_LSB = 0;
	localparam int TGT_EVENT_IDX_LSB = 8;
	localparam int TGT_WAVE_LSB      = 16;
	localparam int TGT_SUB_LAST_LSB  = 24;
	localparam int STEP_IDX_MAX_W    = 8;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] RST_LOOP      = 32'h0000_0001;
	localparam logic [31:0] RST_SEQ_RANGE = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Trigger sources and branch target kinds
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_A   = 2'h1;
	localparam logic [1:0] SRC_B   = 2'h2;
	localparam logic [1:0] SRC_INT = 2'h3;

	localparam logic [2:0] TK_NEXT    = 3'h0;
	localparam logic [2:0] TK_FIRST   = 3'h1;
	localparam logic [2:0] TK_LAST    = 3'h2;
	localparam logic [2:0] TK_END     = 3'h3;
	localparam logic [2:0] TK_INDEX   = 3'h4;
	localparam logic [2:0] TK_CURRENT = 3'h5;

	// Step configuration word, bit 10 down to bit 0
	typedef struct packed {
		logic       is_sub;
		logic [2:0] event_kind;
		logic [2:0] after_kind;
		logic [1:0] event_src;
		logic [1:0] wait_src;
	} wss_step_cfg_t;

	// Command to the waveform playback engine
	typedef struct packed {
		logic       start;
		logic       abort;
		logic [7:0] wave;
	} wss_play_cmd_t;

	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_START, ST_PLAY} wss_state_t;

endpackage

// File: testbench/wss_engine_model.sv
// Stand-in for the waveform playback engine behind the sequencer.
// Assumes one-cycle start and abort pulses on clk_sys; every waveform lasts len cycles.
module wss_engine_model
	import wss_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire wss_play_cmd_t play_cmd,
	input  wire logic [7:0]    len,
	output logic               play_done
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt;
	logic       busy;

	////////////////////////////////////////////////////////////////////////
	// One done pulse per start; an abort drops the play silently
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			busy <= 1'b0;
			play_done <= 1'b0;
		end else begin
			play_done <= 1'b0;
			if (play_cmd.start) begin
				cnt <= len;
				busy <= 1'b1;
			end else if (play_cmd.abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
				if (cnt <= 8'h01) begin
					busy <= 1'b0;
					play_done <= 1'b1;
				end
			end
		end
	end
endmodule

// File: testbench/wss_sequencer_tb.sv
// Self-checking bench for the waveform step sequencer.
// Assumes the engine model beside it and a zero-wait AHB-Lite slave; top sequence is steps 0 to 2.
module wss_sequencer_tb
	import wss_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic          clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, play_done;
	logic          trigger_input_a, trigger_input_b, trigger_internal, pattern_branch_req;
	logic [31:0]   haddr, hwdata, hrdata, rd, mode;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [7:0]    pattern_branch_step, len;
	wss_play_cmd_t play_cmd;
	logic [7:0]    got[$];
	int            aborts, bad_count, n_checks;

	localparam logic [2:0]  ak[3] = '{TK_LAST, TK_FIRST, TK_INDEX};
	localparam logic [31:0] ax[3] = '{32'h12101210, 32'h11101110, 32'h11121110};
	localparam logic [2:0]  ok[4] = '{TK_INDEX, TK_CURRENT, TK_FIRST, TK_LAST};
	localparam logic [8:0]  os[4] = '{9'h101, 9'h101, 9'h100, 9'h102};

	assign hready = hreadyout;

	wss_sequencer dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .trigger_input_a, .trigger_input_b, .trigger_internal,
		.pattern_branch_req, .pattern_branch_step, .play_done, .play_cmd);

	wss_engine_model engine (.clk_sys, .rst_n, .play_cmd, .len, .play_done);

	////////////////////////////////////////////////////////////////////////
	// Record every waveform start and abort
	always @(posedge clk_sys) begin
		if (play_cmd.start === 1'b1) got.push_back(play_cmd.wave);
		if (play_cmd.abort === 1'b1) aborts++;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus, trigger and check tasks
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic pulse(input logic [3:0] w);
		@(posedge clk_sys);
		{pattern_branch_req, trigger_internal, trigger_input_b, trigger_input_a} <= w;
		@(posedge clk_sys);
		{pattern_branch_req, trigger_internal, trigger_input_b, trigger_input_a} <= 4'h0;
	endtask

	task automatic step(input logic [7:0] i, input wss_step_cfg_t c, input logic [31:0] t, input logic [31:0] lp);
		bus(1'b1, OFF_STEP_SEL, {24'h0, i});
		bus(1'b1, OFF_STEP_CFG, {21'h0, c});
		bus(1'b1, OFF_STEP_TGT, t);
		bus(1'b1, OFF_STEP_LOOP, lp);
	endtask

	// Let the abort pulse of a stop be counted before a following go() clears the count
	task automatic halt;
		bus(1'b1, OFF_CTRL, mode | 32'h4);
		repeat (2) @(posedge clk_sys);
	endtask

	// Steps 0 to 5 back to defaults; step i plays waveform 0x10 + i
	task automatic clean;
		halt();
		for (int i = 0; i < 6; i++) step(i[7:0], '0, {8'h0, 8'h10 + i[7:0], 16'h0001}, 32'h1);
	endtask

	task automatic go;
		got.delete();
		aborts = 0;
		bus(1'b1, OFF_CTRL, mode | 32'h1);
	endtask

	// Bounded wait: a missing start leaves an unknown entry that fails its compare
	task automatic waitn(input int n);
		for (int k = 0; k < 400 && got.size() < n; k++) @(posedge clk_sys);
	endtask

	task automatic run(input int n, input logic [31:0] e);
		go();
		waitn(n);
		halt();
		for (int i = 0; i < n; i++) chk({24'h0, got[i]}, {24'h0, e[8*i +: 8]});
	endtask

	task automatic conclude;
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#300us;
		bad_count++;
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		{pattern_branch_req, trigger_internal, trigger_input_b, trigger_input_a} = 4'h0;
		pattern_branch_step = 8'h01;
		len = 8'h06;
		mode = 32'h0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, OFF_STEP_LOOP, 32'h0);
		chk(rd, RST_LOOP);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, OFF_SEQ_RANGE, 32'h0000_0200);
		clean();
		run(4, 32'h10121110);
		step(8'h0, '0, 32'h0010_0001, 32'h2);
		run(4, 32'h12111010);
		step(8'h0, '0, 32'h0010_0001, 32'h0);
		run(4, 32'h10101010);
		for (int i = 0; i < 3; i++) begin
			clean();
			step(i[7:0], '{1'b0, TK_NEXT, ak[i], SRC_OFF, SRC_OFF}, {8'h0, 8'h10 + i[7:0], 16'h0001}, 32'h1);
			run(4, ax[i]);
		end
		// A step that ends the sequence
		clean();
		step(8'h1, '{1'b0, TK_NEXT, TK_END, SRC_OFF, SRC_OFF}, 32'h0011_0001, 32'h1);
		go();
		repeat (80) @(posedge clk_sys);
		chk(got.size(), 2);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd[17], 1'b0);
		// Step 1 waits for trigger A; B must not release it
		clean();
		step(8'h1, '{1'b0, TK_NEXT, TK_NEXT, SRC_OFF, SRC_A}, 32'h0011_0001, 32'h1);
		go();
		repeat (40) @(posedge clk_sys);
		pulse(4'h2);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(got.size(), 1);
		chk(rd[18], 1'b1);
		pulse(4'h1);
		waitn(2);
		chk({24'h0, got[1]}, 32'h11);
		// Event on B to step 2 while after-step points at step 1
		clean();
		len <= 8'd40;
		step(8'h0, '{1'b0, TK_INDEX, TK_INDEX, SRC_B, SRC_OFF}, 32'h0010_0201, 32'h1);
		go();
		waitn(1);
		pulse(4'h2);
		waitn(2);
		chk({24'h0, got[1]}, 32'h12);
		chk(aborts, 1);
		// Deferred: pattern and event together, pattern wins at waveform end
		halt();
		mode = 32'h2;
		go();
		waitn(1);
		pulse(4'hA);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd[19], 1'b1);
		waitn(2);
		chk({24'h0, got[1]}, 32'h11);
		chk(aborts, 0);
		mode = 32'h0;
		clean();
		foreach (ok[i]) begin
			got.delete();
			bus(1'b1, OFF_OVERRIDE, {21'h0, ok[i], 8'h01});
			waitn(1);
			bus(1'b0, OFF_STATUS, 32'h0);
			chk({23'h0, rd[17], rd[7:0]}, {23'h0, os[i]});
			chk({24'h0, got[0]}, {24'h0, 8'h10 + os[i][7:0]});
		end
		bus(1'b1, OFF_OVERRIDE, {21'h0, TK_END, 8'h00});
		repeat (10) @(posedge clk_sys);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd[17], 1'b0);
		// Step 1 is a one-level subsequence over steps 4..5 whose wait and event are ignored
		clean();
		len <= 8'h06;
		step(8'h1, '{1'b1, TK_NEXT, TK_NEXT, SRC_OFF, SRC_OFF}, 32'h0504_0001, 32'h1);
		step(8'h4, '{1'b0, TK_FIRST, TK_NEXT, SRC_A, SRC_B}, 32'h0014_0001, 32'h1);
		go();
		waitn(2);
		pulse(4'h1);
		waitn(4);
		halt();
		for (int i = 0; i < 4; i++) chk({24'h0, got[i]}, {24'h0, 8'(32'h12151410 >> (8 * i))});
		conclude();
	end
endmodule
